// file: hdl/clock_prescaler_and_rc_trim.sv
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler_and_rc_trim (
  input  wire logic                   core_clk_i,
  input  wire logic                   rst_n_i,
  input  wire clk_ctrl_pkg::apb_req_s apb_req_i,
  output clk_ctrl_pkg::apb_rsp_s      apb_rsp_o,
  input  wire logic [7:0]             factory_trim_i,
  input  wire logic                   divide_by_eight_fuse_i,
  output logic [7:0]                  trim_value_o,
  output logic                        sys_clk_en_o,
  output logic [3:0]                  active_divide_o
);
  import clk_ctrl_pkg::*;

  //////////////////////////////////////////////////////////////////////////////

  logic [7:0] factory_trim_sync;
  logic       fuse_sync;
  logic [1:0] boot_count;
  logic       booting;
  logic [3:0] divide_select;
  logic       divider_change_unlock;
  logic [1:0] unlock_age;

  // Factory value and fuse come from outside this clock, so they are synchronised first.
  pin_sync #(
    .WIDTH (9)
  ) u_strap_sync (
    .core_clk_i (core_clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    ({divide_by_eight_fuse_i, factory_trim_i}),
    .sync_o     ({fuse_sync, factory_trim_sync})
  );

  // The divided system clock is a one-cycle enable pulse.
  clock_enable_divider u_divider (
    .core_clk_i      (core_clk_i),
    .rst_n_i         (rst_n_i),
    .select_i        (divide_select),
    .tick_o          (sys_clk_en_o),
    .active_select_o (active_divide_o)
  );

  //////////////////////////////////////////////////////////////////////////////

  // Bus decode; a transfer completes at the edge where pready is seen high.
  wire       access_phase = apb_req_i.psel && apb_req_i.penable;
  wire       transfer_end = access_phase && apb_rsp_o.pready;
  wire       hit_divider  = (apb_req_i.paddr == ADDR_SYS_CLOCK_DIVIDER);
  wire       hit_trim     = (apb_req_i.paddr == ADDR_RC_OSC_TRIM);
  wire       write_end    = transfer_end && apb_req_i.pwrite;
  wire [7:0] wdata        = apb_req_i.pwdata[7:0];
  wire       answer_now   = access_phase && !apb_rsp_o.pready && !booting;

  // Divider write classification.
  wire write_divider = write_end && hit_divider;
  wire unlock_write  = write_divider && wdata[UNLOCK_BIT] && (wdata[6:0] == 7'h00);
  wire select_write  = write_divider && !unlock_write;
  wire select_accept = select_write && divider_change_unlock && !wdata[UNLOCK_BIT];
  wire unlock_expire = divider_change_unlock && (unlock_age == UNLOCK_CYCLES);
  wire write_trim    = write_end && hit_trim;

  // Read data mux; bits above the register width and the reserved bits read zero.
  wire [31:0] read_word = hit_divider ? {24'h00_0000, divider_change_unlock, 3'b000, divide_select}
                        : hit_trim    ? {24'h00_0000, trim_value_o}
                        : 32'h0000_0000;

  //////////////////////////////////////////////////////////////////////////////

  // Straps are loaded for a few cycles after reset release, once the synchronisers are settled.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      boot_count <= 2'd0;
    end else if (booting) begin
      boot_count <= boot_count + 2'd1;
    end
  end

  assign booting = (boot_count != BOOT_CYCLES);

  // Trim register; the full byte drives the oscillator, bit 7 the range and bits 6..0 the fine step.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      trim_value_o <= TRIM_RESET;
    end else if (booting) begin
      trim_value_o <= factory_trim_sync;
    end else if (write_trim) begin
      trim_value_o <= wdata;
    end
  end

  // Divide select field; reset value chosen from the fuse, later only changed while unlocked.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divide_select <= SELECT_RESET_FUSE_CLEAR;
    end else if (booting) begin
      divide_select <= fuse_sync ? SELECT_RESET_FUSE_SET : SELECT_RESET_FUSE_CLEAR;
    end else if (select_accept) begin
      divide_select <= wdata[SELECT_MSB:0];
    end
  end

  // Unlock bit with a fixed window that a repeated unlock write does not restart.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      divider_change_unlock <= 1'b0;
      unlock_age            <= 2'd0;
    end else if (select_write || unlock_expire) begin
      divider_change_unlock <= 1'b0;
      unlock_age            <= 2'd0;
    end else if (divider_change_unlock) begin
      unlock_age <= unlock_age + 2'd1;
    end else if (unlock_write) begin
      divider_change_unlock <= 1'b1;
      unlock_age            <= 2'd0;
    end
  end

  // Bus answer: after boot, pready rises one cycle into the access phase, for one cycle only.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      apb_rsp_o <= '0;
    end else begin
      apb_rsp_o.pready  <= answer_now;
      apb_rsp_o.pslverr <= answer_now && !(hit_divider || hit_trim);
      if (answer_now && !apb_req_i.pwrite) begin
        apb_rsp_o.prdata <= read_word;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////

  default clocking cb @(posedge core_clk_i); endclocking
  default disable iff (!rst_n_i);

  // Unlock never stays set longer than its window.
  property p_unlock_window;
    $rose(divider_change_unlock) |-> ##[1:4] !divider_change_unlock;
  endproperty
  a_unlock_window: assert property (p_unlock_window) else $error("unlock bit outlived its window");

  // Without a select write, unlock holds exactly four cycles.
  property p_unlock_full;
    $rose(divider_change_unlock) ##1 (!select_write)[*3] |=> !divider_change_unlock;
  endproperty
  a_unlock_full: assert property (p_unlock_full) else $error("unlock bit length wrong");

  // A write with other bits set never sets unlock.
  property p_unlock_clean;
    (write_divider && wdata[6:0] != 7'h00 && !divider_change_unlock) |=> !divider_change_unlock;
  endproperty
  a_unlock_clean: assert property (p_unlock_clean) else $error("unlock set by dirty write");

  // A locked select write leaves the setting alone.
  property p_locked_select;
    (select_write && !divider_change_unlock && !booting) |=> $stable(divide_select);
  endproperty
  a_locked_select: assert property (p_locked_select) else $error("select changed while locked");

  // An unlocked select write takes the value and closes the window.
  property p_unlocked_select;
    (select_accept && !booting) |=> (divide_select == $past(wdata[3:0])) && !divider_change_unlock;
  endproperty
  a_unlocked_select: assert property (p_unlocked_select) else $error("unlocked select write lost");

  // A trim write reaches the oscillator on the next cycle.
  property p_trim_write;
    (write_trim && !booting) |=> trim_value_o == $past(wdata);
  endproperty
  a_trim_write: assert property (p_trim_write) else $error("trim write not applied");

  // After boot the trim equals the factory value and the select matches the fuse.
  property p_boot_values;
    $fell(booting) |-> trim_value_o == $past(factory_trim_sync) &&
      divide_select == ($past(fuse_sync) ? SELECT_RESET_FUSE_SET : SELECT_RESET_FUSE_CLEAR);
  endproperty
  a_boot_values: assert property (p_boot_values) else $error("boot values wrong");

  // Reserved divider bits always read as zero.
  property p_reserved_zero;
    (apb_rsp_o.pready && !apb_req_i.pwrite && hit_divider) |-> apb_rsp_o.prdata[6:4] == 3'b000;
  endproperty
  a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits read nonzero");

  // A new setting is in force at most one old period after it is written.
  property p_switch_time;
    (active_divide_o == 4'h0 && divide_select == 4'h1 && $changed(divide_select)) |-> ##[1:4] active_divide_o == 4'h1;
  endproperty
  a_switch_time: assert property (p_switch_time) else $error("divider switch too slow");

  //////////////////////////////////////////////////////////////////////////////

  // The unlock age never runs past the end of its window.
  property p_unlock_age_bound;
    divider_change_unlock |-> unlock_age <= UNLOCK_CYCLES;
  endproperty
  a_unlock_age_bound: assert property (p_unlock_age_bound) else $error("unlock age out of range");

  // Unlock only rises after a clean unlock write.
  property p_unlock_source;
    $rose(divider_change_unlock) |-> $past(unlock_write);
  endproperty
  a_unlock_source: assert property (p_unlock_source) else $error("unlock rose without clean write");

  // A clean unlock write while locked always opens the window.
  property p_unlock_set_clean;
    (unlock_write && !divider_change_unlock) |=> divider_change_unlock;
  endproperty
  a_unlock_set_clean: assert property (p_unlock_set_clean) else $error("clean unlock write ignored");

  // A repeated unlock write lets the age run on and keeps the bit set.
  property p_no_restart;
    (unlock_write && divider_change_unlock && !unlock_expire) |=>
      divider_change_unlock && (unlock_age == 2'($past(unlock_age) + 2'd1));
  endproperty
  a_no_restart: assert property (p_no_restart) else $error("unlock window restarted");

  // The window closes right after its last cycle.
  property p_lock_after_window;
    unlock_expire |=> !divider_change_unlock;
  endproperty
  a_lock_after_window: assert property (p_lock_after_window) else $error("unlock outlived expiry");

  // Any select write closes the window.
  property p_select_write_clears;
    select_write |=> !divider_change_unlock;
  endproperty
  a_select_write_clears: assert property (p_select_write_clears) else $error("select write kept unlock");

  // Nothing can unlock the divider while the straps are still loading.
  property p_boot_locked;
    booting |-> !divider_change_unlock;
  endproperty
  a_boot_locked: assert property (p_boot_locked) else $error("unlock set during boot");

  // The select field only moves through an accepted select write once boot is over.
  property p_select_needs_unlock;
    ($changed(divide_select) && !$past(booting)) |-> $past(select_accept);
  endproperty
  a_select_needs_unlock: assert property (p_select_needs_unlock) else $error("select moved without unlock");

  // Without an accepted write the select field holds.
  property p_select_hold;
    (!select_accept && !booting) |=> $stable(divide_select);
  endproperty
  a_select_hold: assert property (p_select_hold) else $error("select changed by itself");

  // Without a trim write the oscillator setting holds.
  property p_trim_hold;
    (!write_trim && !booting) |=> $stable(trim_value_o);
  endproperty
  a_trim_hold: assert property (p_trim_hold) else $error("trim changed by itself");

  // A trim read returns the value that drives the oscillator.
  property p_read_trim;
    (apb_rsp_o.pready && !apb_req_i.pwrite && hit_trim) |->
      apb_rsp_o.prdata == {24'h00_0000, trim_value_o};
  endproperty
  a_read_trim: assert property (p_read_trim) else $error("trim read wrong");

  // Bits above the register byte always read as zero.
  property p_read_upper_zero;
    (apb_rsp_o.pready && !apb_req_i.pwrite) |-> apb_rsp_o.prdata[31:8] == 24'h00_0000;
  endproperty
  a_read_upper_zero: assert property (p_read_upper_zero) else $error("upper read bits nonzero");

  //////////////////////////////////////////////////////////////////////////////

  // An access phase seen after boot is answered on the next cycle.
  property p_pready_timing;
    answer_now |=> apb_rsp_o.pready;
  endproperty
  a_pready_timing: assert property (p_pready_timing) else $error("bus answer late");

  // The answer stands for one cycle only.
  property p_pready_pulse;
    apb_rsp_o.pready |=> !apb_rsp_o.pready;
  endproperty
  a_pready_pulse: assert property (p_pready_pulse) else $error("bus answer too long");

  // No answer is given while the straps are loading.
  property p_no_answer_boot;
    booting |=> !apb_rsp_o.pready;
  endproperty
  a_no_answer_boot: assert property (p_no_answer_boot) else $error("bus answered during boot");

  // An error flag only comes with the answer.
  property p_slverr_with_ready;
    apb_rsp_o.pslverr |-> apb_rsp_o.pready;
  endproperty
  a_slverr_with_ready: assert property (p_slverr_with_ready) else $error("error without answer");

  //////////////////////////////////////////////////////////////////////////////

  // Divide by one gives an enable on every cycle.
  property p_tick_undivided;
    (active_divide_o == 4'h0) |=> sys_clk_en_o;
  endproperty
  a_tick_undivided: assert property (p_tick_undivided) else $error("undivided enable missing");

  // A new setting is adopted only at the end of a running period.
  property p_adopt_on_tick;
    $changed(active_divide_o) |-> sys_clk_en_o;
  endproperty
  a_adopt_on_tick: assert property (p_adopt_on_tick) else $error("setting adopted mid period");

  c_unlock_then_select: cover property (unlock_write ##[1:4] select_accept);
  c_trim_write: cover property (write_trim);
  c_reserved_code: cover property (select_accept && wdata[3:0] > SELECT_MAX_CODE);
  c_unmapped: cover property (apb_rsp_o.pready && apb_rsp_o.pslverr);
  c_adopt: cover property ($changed(active_divide_o));

endmodule
`default_nettype wire

// file: pkg/clk_ctrl_pkg.sv
`default_nettype none
package clk_ctrl_pkg;

  // Register indices; the byte address on the bus is four times the index.
  localparam logic [7:0]  IDX_SYS_CLOCK_DIVIDER = 8'h26;
  localparam logic [7:0]  IDX_RC_OSC_TRIM       = 8'h27;
  localparam logic [31:0] ADDR_SYS_CLOCK_DIVIDER = {22'h00_0000, IDX_SYS_CLOCK_DIVIDER, 2'b00};
  localparam logic [31:0] ADDR_RC_OSC_TRIM       = {22'h00_0000, IDX_RC_OSC_TRIM, 2'b00};

  // Field positions of the divider and trim registers.
  localparam int UNLOCK_BIT     = 7;
  localparam int SELECT_MSB     = 3;
  localparam int TRIM_RANGE_BIT = 7;

  // Reset values of the divide select field and the trim, and the highest regular select code.
  localparam logic [3:0] SELECT_RESET_FUSE_SET   = 4'h3;
  localparam logic [3:0] SELECT_RESET_FUSE_CLEAR = 4'h0;
  localparam logic [3:0] SELECT_MAX_CODE         = 4'h8;
  localparam logic [7:0] TRIM_RESET              = 8'h00;

  // Timing counts in core clock cycles.
  localparam logic [1:0] UNLOCK_CYCLES = 2'd3;
  localparam logic [1:0] BOOT_CYCLES   = 2'd3;

  // APB request from the master.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [31:0] paddr;
    logic [31:0] pwdata;
  } apb_req_s;

  // APB answer of the slave.
  typedef struct packed {
    logic        pready;
    logic        pslverr;
    logic [31:0] prdata;
  } apb_rsp_s;

endpackage
`default_nettype wire

// file: hdl/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
  parameter int WIDTH = 1
) (
  input  wire logic             core_clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] stage1;

  // Two flops per bit; only the second flop reads the first.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      stage1 <= '0;
      sync_o <= '0;
    end else begin
      stage1 <= async_i;
      sync_o <= stage1;
    end
  end

endmodule
`default_nettype wire

// file: hdl/clock_enable_divider.sv
`timescale 1ns/1ps
`default_nettype none
module clock_enable_divider (
  input  wire logic       core_clk_i,
  input  wire logic       rst_n_i,
  input  wire logic [3:0] select_i,
  output logic            tick_o,
  output logic [3:0]      active_select_o
);
  import clk_ctrl_pkg::*;

  logic [7:0] count;
  logic [7:0] limit;
  logic       period_end;

  // Reserved codes divide by 256; code n otherwise divides by two to the n.
  assign limit      = (active_select_o > SELECT_MAX_CODE) ? 8'hFF
                    : 8'((9'h001 << active_select_o) - 9'h001);
  assign period_end = (count == limit);

  // A new setting is adopted only when the running period ends, so no period is cut short.
  always_ff @(posedge core_clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      count           <= 8'h00;
      tick_o          <= 1'b0;
      active_select_o <= 4'h0;
    end else begin
      tick_o <= period_end;
      if (period_end) begin
        count           <= 8'h00;
        active_select_o <= select_i;
      end else begin
        count <= count + 8'h01;
      end
    end
  end

endmodule
`default_nettype wire

// file: sim/clock_prescaler_and_rc_trim_bench.sv
`timescale 1ns/1ps
`default_nettype none
module clock_prescaler_and_rc_trim_bench;
  import clk_ctrl_pkg::*;

  logic       core_clk;
  logic       rst_n;
  apb_req_s   req;
  apb_rsp_s   rsp;
  logic [7:0] factory_trim;
  logic       fuse;
  logic [7:0] trim_value;
  logic       sys_clk_en;
  logic [3:0] active_divide;
  int         fail_count;
  int         n_compared;
  int         seed;
  logic [31:0] rd;
  logic       er;
  logic [3:0] cur_sel;
  logic [7:0] v;

  clock_prescaler_and_rc_trim u_dut (
    .core_clk_i             (core_clk),
    .rst_n_i                (rst_n),
    .apb_req_i              (req),
    .apb_rsp_o              (rsp),
    .factory_trim_i         (factory_trim),
    .divide_by_eight_fuse_i (fuse),
    .trim_value_o           (trim_value),
    .sys_clk_en_o           (sys_clk_en),
    .active_divide_o        (active_divide)
  );

  ////////////////////////////////////////////////////////////////////////
  // The clock toggles every half period of 5 ns.
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  // Prints the counts and the verdict, then ends the run.
  task complete_run();
    $display("compared %0d, mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  // Compares a seen value with the expected one.
  task chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("[ERR] %0t seen %h expected %h", $time, got, exp);
    end
  endtask

  // One APB transfer, entered at a rising edge; the request stays until pready.
  task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
    int i;
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: d};
    @(posedge core_clk);
    req.penable <= 1'b1;
    i = 0;
    do begin
      @(posedge core_clk);
      i++;
    end while (rsp.pready !== 1'b1 && i < 50);
    if (i >= 50) begin
      fail_count++;
      $display("[ERR] %0t no bus answer", $time);
      complete_run();
    end
    rd = rsp.prdata;
    er = rsp.pslverr;
  endtask

  // Releases the bus for one cycle.
  task idle();
    req.psel    <= 1'b0;
    req.penable <= 1'b0;
    @(posedge core_clk);
  endtask

  // Holds reset for 12 cycles with the given straps.
  task do_reset(input logic f, input logic [7:0] t);
    req          <= '0;
    fuse         <= f;
    factory_trim <= t;
    rst_n        <= 1'b0;
    repeat (12) @(posedge core_clk);
    rst_n <= 1'b1;
    @(posedge core_clk);
  endtask

  // Reads the divider back against the expected select value.
  task chk_div();
    apb(1'b0, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0000);
    chk(rd, {28'h000_0000, cur_sel});
  endtask

  // Unlock, a gap of idle cycles, then a select write.
  task change(input logic [3:0] code, input int gap);
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0080);
    repeat (gap) idle();
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, {28'h000_0000, code});
    if (gap <= 1) cur_sel = code;
    chk_div();
  endtask

  // Expected enable period: powers of two, reserved codes run at 256.
  function automatic int period(input logic [3:0] c);
    return (c > 4'h8) ? 256 : (1 << c);
  endfunction

  // Waits for the setting to be adopted, then times one enable period.
  task measure();
    int n;
    idle();
    n = 0;
    while (active_divide !== cur_sel && n < 700) begin
      @(posedge core_clk);
      n++;
    end
    if (n >= 700) begin
      fail_count++;
      $display("[ERR] %0t divider never adopted the setting", $time);
      complete_run();
    end
    chk(active_divide, cur_sel);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sys_clk_en !== 1'b1 && n < 300);
    n = 0;
    do begin
      @(posedge core_clk);
      n++;
    end while (sys_clk_en !== 1'b1 && n < 300);
    chk(n, period(cur_sel));
  endtask

  ////////////////////////////////////////////////////////////////////////
  // Main sequence of scenarios.
  initial begin
    req = '0;
    rst_n = 1'b0;
    fuse = 1'b1;
    factory_trim = 8'h00;
    fail_count = 0;
    n_compared = 0;
    seed = 32'h0293_a82c;
    v = {4'h7, 4'($random(seed))};
    do_reset(1'b1, v);
    apb(1'b0, ADDR_RC_OSC_TRIM, 32'h0000_0000);
    chk(rd, {24'h00_0000, v});
    chk(trim_value, v);
    cur_sel = 4'h3;
    chk_div();
    measure();
    apb(1'b0, 32'h0000_0000, 32'h0000_0000);
    chk(er, 1'b1);
    chk(rd, 32'h0000_0000);
    $display("test reset and unmapped done");
    for (int i = 0; i < 6; i++) begin
      // Steps stay within 0x20; each value is written, then read back.
      v = (i == 0) ? 8'h7f : (i == 1) ? 8'h80 : v ^ {3'b000, 5'($random(seed))};
      apb(1'b1, ADDR_RC_OSC_TRIM, {24'($random(seed)), v});
      apb(1'b0, ADDR_RC_OSC_TRIM, 32'h0000_0000);
      chk(rd, {24'h00_0000, v});
      chk(trim_value, v);
    end
    $display("test trim done");
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0005);
    chk_div();
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0081);
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0002);
    chk_div();
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0080);
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0080);
    apb(1'b1, ADDR_SYS_CLOCK_DIVIDER, 32'h0000_0006);
    chk_div();
    change(4'h4, 2);
    $display("test locked writes done");
    for (int i = 0; i < 7; i++) begin
      v = (i < 4) ? {4'h0, i == 0 ? 4'h0 : i == 1 ? 4'h8 : i == 2 ? 4'h9 : 4'hf} : 8'($unsigned($random(seed)) % 9);
      change(v[3:0], i % 2);
      measure();
    end
    $display("test divide codes done");
    do_reset(1'b0, 8'h5a);
    cur_sel = 4'h0;
    chk_div();
    chk(trim_value, 8'h5a);
    measure();
    $display("test second reset done");
    complete_run();
  end

endmodule
`default_nettype wire
